// ==== core/cadp_aux_file.sv ====
`timescale 1ns/1ps
`default_nettype none
module cadp_aux_file #(
   parameter int N = cadp_pkg::AUX_N,
   parameter int W = cadp_pkg::HALF_W
) (
   input wire logic clock_i,                      // CPU clock
   input wire logic reset_i,                      // Sync reset
   input wire logic [cadp_pkg::PTR_W-1:0] ptr_i,  // Current register
   input wire logic wr_en_i,                      // Load strobe
   input wire logic [cadp_pkg::PTR_W-1:0] wr_idx_i, // Load target
   input wire logic [W-1:0] wr_data_i,            // Load value
   input wire logic mod_en_i,                     // Indirect access
   input wire cadp_pkg::cadp_ind_e mod_mode_i,    // Modify kind
   input wire logic [cadp_pkg::PTR_W-1:0] pick_idx_i, // Side read index
   output logic [W-1:0] cur_o,                    // Current register
   output logic [W-1:0] pick_o                    // Side read value
);
   import cadp_pkg::*;
   logic [W-1:0] regs_r [N];
   logic [W-1:0] step;
   logic [W-1:0] cur;

   assign cur = regs_r[ptr_i];

   always_comb begin
      step = cur;
      unique case (mod_mode_i)
         ind_none: step = cur;
         ind_inc: step = cur + W'(1);
         ind_dec: step = cur - W'(1);
         ind_add_index: step = cur + regs_r[INDEX_REG];
         ind_sub_index: step = cur - regs_r[INDEX_REG];
         default: step = cur;
      endcase
   end

   // Explicit load beats the address-unit step on the same register
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         for (int i = 0; i < N; i++) begin
            regs_r[i] <= '0;
         end
      end else begin
         if (mod_en_i) begin
            regs_r[ptr_i] <= step;
         end
         if (wr_en_i) begin
            regs_r[wr_idx_i] <= wr_data_i;
         end
      end
   end

   assign cur_o = cur;
   assign pick_o = regs_r[pick_idx_i];
endmodule : cadp_aux_file
`default_nettype wire

// ==== core/cadp_datapath.sv ====
`timescale 1ns/1ps
`default_nettype none
module cadp_datapath (
   input wire logic clock_i,                        // CPU clock, 200 MHz
   input wire logic reset_i,                        // Sync reset, active high
   input wire logic wb_cyc_i,                       // Wishbone cycle
   input wire logic wb_stb_i,                       // Wishbone strobe
   input wire logic wb_we_i,                        // Wishbone write
   input wire logic [cadp_pkg::ADR_W-1:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i,                 // Byte enables
   input wire logic [cadp_pkg::WB_W-1:0] wb_dat_i,  // Write data
   output logic [cadp_pkg::WB_W-1:0] wb_dat_o,      // Read data
   output logic wb_ack_o,                           // Acknowledge
   input wire logic op_valid_i,                     // Decoder issues op
   input wire cadp_pkg::cadp_op_e op_code_i,        // Operation
   input wire logic [cadp_pkg::HALF_W-1:0] op_operand_i, // Memory or immediate
   input wire logic [cadp_pkg::SHIFT_W-1:0] op_shift_i,  // Store shift
   input wire logic [cadp_pkg::RPT_W-1:0] op_count_i,    // Extra repeats
   input wire cadp_pkg::cadp_src_e aux_src_i,       // Aux/pointer load source
   input wire logic [cadp_pkg::PTR_W-1:0] aux_sel_i, // Aux register addressed
   input wire logic [cadp_pkg::ACC_W-1:0] product_i, // Product register
   input wire logic ind_valid_i,                    // Indirect access
   input wire cadp_pkg::cadp_ind_e ind_mode_i,      // Address step
   output logic op_ready_o,                         // Ready for next op
   output logic [cadp_pkg::HALF_W-1:0] store_data_o, // Data bus value
   output logic store_valid_o,                      // Store strobe
   output logic [cadp_pkg::HALF_W-1:0] data_addr_o, // Indirect address
   output logic [cadp_pkg::PTR_W-1:0] aux_pointer_o, // Pointer
   output logic cond_c_o,                           // Carry set
   output logic cond_nc_o,                          // Carry clear
   output logic overflow_o,                         // Sticky overflow
   output logic [cadp_pkg::ACC_W-1:0] acc_o         // Accumulator
);
   import cadp_pkg::*;

   logic [ACC_W-1:0] accumulator_reg, acc_nxt;
   logic carry_r, carry_nxt;
   logic ovf_r;
   logic [CTRL_W-1:0] ctrl_r;
   logic [PTR_W-1:0] aux_pointer;
   logic sign_extend_mode, saturation_enable;
   cadp_op_e rep_op_r, eop;
   logic [HALF_W-1:0] rep_opnd_r, opnd;
   logic [SHIFT_W-1:0] rep_shift_r, sh;
   logic [PTR_W-1:0] rep_sel_r, sel;
   cadp_src_e rep_src_r, src;
   logic [RPT_W-1:0] rep_cnt_r;
   logic busy, exec;
   logic [ACC_W-1:0] opnd_ext, addend, arith, sat_val, shifted_acc;
   logic [ACC_W:0] sum, diff;
   logic cin, do_add, do_sub, cout, ovf;
   logic [HALF_W-1:0] aux_cur, aux_pick, src_word, store_hi_w, store_lo_w;
   logic acc_msb, acc_lsb;
   logic aux_wr;
   logic [HALF_W-1:0] store_data_r;
   logic store_valid_r;
   logic ack_r;
   logic [WB_W-1:0] rdata_r;
   logic wb_take, wb_wr;

   assign sign_extend_mode = ctrl_r[CTRL_SXM_BIT];
   assign saturation_enable = ctrl_r[CTRL_OVM_BIT];

   // Repeat: the captured op replays once per cycle until the count runs out
   assign busy = rep_cnt_r != '0;
   assign exec = busy | op_valid_i;
   assign eop = busy ? rep_op_r : op_code_i;
   assign opnd = busy ? rep_opnd_r : op_operand_i;
   assign sh = busy ? rep_shift_r : op_shift_i;
   assign sel = busy ? rep_sel_r : aux_sel_i;
   assign src = busy ? rep_src_r : aux_src_i;
   assign op_ready_o = !busy;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         rep_cnt_r <= '0;
         rep_op_r <= nop_op;
         rep_opnd_r <= '0;
         rep_shift_r <= '0;
         rep_sel_r <= '0;
         rep_src_r <= src_operand;
      end else if (op_valid_i && !busy) begin
         rep_cnt_r <= op_count_i;
         rep_op_r <= op_code_i;
         rep_opnd_r <= op_operand_i;
         rep_shift_r <= op_shift_i;
         rep_sel_r <= aux_sel_i;
         rep_src_r <= aux_src_i;
      end else if (busy) begin
         rep_cnt_r <= rep_cnt_r - RPT_W'(1);
      end
   end

   assign opnd_ext = sign_extend_mode ? {{HALF_W{opnd[HALF_W-1]}}, opnd} : {HALF_ZERO, opnd};

   // Operand selection for the central arithmetic unit
   always_comb begin
      addend = opnd_ext;
      cin = 1'b0;
      do_add = 1'b0;
      do_sub = 1'b0;
      case (eop)
         add_op: do_add = 1'b1;
         add_high_op: begin
            addend = {opnd, HALF_ZERO};
            do_add = 1'b1;
         end
         add_with_carry_op: begin
            do_add = 1'b1;
            cin = carry_r;
         end
         add_product_op: begin
            addend = product_i;
            do_add = 1'b1;
         end
         add_aux_op: begin
            addend = {HALF_ZERO, aux_pick};
            do_add = 1'b1;
         end
         sub_op: do_sub = 1'b1;
         sub_high_op: begin
            addend = {opnd, HALF_ZERO};
            do_sub = 1'b1;
         end
         sub_with_borrow_op: begin
            do_sub = 1'b1;
            cin = !carry_r;
         end
         default: ;
      endcase
   end

   assign sum = {1'b0, accumulator_reg} + {1'b0, addend} + {{ACC_W{1'b0}}, cin};
   assign diff = {1'b0, accumulator_reg} - {1'b0, addend} - {{ACC_W{1'b0}}, cin};
   assign arith = do_sub ? diff[ACC_W-1:0] : sum[ACC_W-1:0];
   // Carry means no borrow on subtraction
   assign cout = do_sub ? !diff[ACC_W] : sum[ACC_W];
   assign acc_msb = accumulator_reg[ACC_W-1];
   assign acc_lsb = accumulator_reg[0];
   assign ovf = (do_add && (acc_msb == addend[ACC_W-1]) && (arith[ACC_W-1] != acc_msb)) ||
                (do_sub && (acc_msb != addend[ACC_W-1]) && (arith[ACC_W-1] != acc_msb));
   assign sat_val = acc_msb ? SAT_NEG : SAT_POS;

   always_comb begin
      acc_nxt = accumulator_reg;
      carry_nxt = carry_r;
      if (exec) begin
         case (eop)
            load_acc_op: acc_nxt = opnd_ext;
            add_op, sub_op, add_with_carry_op, sub_with_borrow_op, add_product_op, add_aux_op: begin
               acc_nxt = (ovf && saturation_enable) ? sat_val : arith;
               carry_nxt = cout;
            end
            add_high_op: begin
               acc_nxt = (ovf && saturation_enable) ? sat_val : arith;
               if (cout) begin
                  carry_nxt = 1'b1;
               end
            end
            sub_high_op: begin
               acc_nxt = (ovf && saturation_enable) ? sat_val : arith;
               if (!cout) begin
                  carry_nxt = 1'b0;
               end
            end
            and_op: acc_nxt = accumulator_reg & {HALF_ZERO, opnd};
            or_op: acc_nxt = accumulator_reg | {HALF_ZERO, opnd};
            xor_op: acc_nxt = accumulator_reg ^ {HALF_ZERO, opnd};
            set_flag_op: carry_nxt = 1'b1;
            clear_flag_op: carry_nxt = 1'b0;
            load_status_op: carry_nxt = opnd[LOADST_CARRY_BIT];
            shift_left_one_op: begin
               acc_nxt = {accumulator_reg[ACC_W-2:0], 1'b0};
               carry_nxt = acc_msb;
            end
            shift_right_one_op: begin
               acc_nxt = {sign_extend_mode & acc_msb, accumulator_reg[ACC_W-1:1]};
               carry_nxt = acc_lsb;
            end
            rotate_left_op: begin
               acc_nxt = {accumulator_reg[ACC_W-2:0], carry_r};
               carry_nxt = acc_msb;
            end
            rotate_right_op: begin
               acc_nxt = {carry_r, accumulator_reg[ACC_W-1:1]};
               carry_nxt = acc_lsb;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         accumulator_reg <= '0;
         carry_r <= CARRY_RESET;
      end else begin
         accumulator_reg <= acc_nxt;
         carry_r <= carry_nxt;
      end
   end

   // Overflow flag: a new overflow wins over a software clear
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ovf_r <= 1'b0;
      end else if (exec && ovf) begin
         ovf_r <= 1'b1;
      end else if (wb_wr && wb_adr_i == REG_STATUS && wb_sel_i[0] && wb_dat_i[STAT_OVF_BIT]) begin
         ovf_r <= 1'b0;
      end
   end

   // Post-scaling store path; accumulator left intact
   assign shifted_acc = accumulator_reg << sh;
   assign store_hi_w = shifted_acc[ACC_W-1:HALF_W];
   assign store_lo_w = accumulator_reg[HALF_W-1:0] << sh;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         store_data_r <= '0;
         store_valid_r <= 1'b0;
      end else begin
         store_valid_r <= exec && (eop == store_high_op || eop == store_low_op || eop == store_aux_op);
         if (exec && eop == store_high_op) begin
            store_data_r <= store_hi_w;
         end else if (exec && eop == store_low_op) begin
            store_data_r <= store_lo_w;
         end else if (exec && eop == store_aux_op) begin
            store_data_r <= aux_pick;
         end
      end
   end

   // Auxiliary registers and pointer
   always_comb begin
      unique case (src)
         src_operand: src_word = opnd;
         src_acc: src_word = accumulator_reg[HALF_W-1:0];
         src_product: src_word = product_i[HALF_W-1:0];
         default: src_word = opnd;
      endcase
   end

   assign aux_wr = exec && eop == load_aux_op;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         aux_pointer <= '0;
      end else if (exec && eop == load_pointer_op) begin
         aux_pointer <= src_word[PTR_W-1:0];
      end
   end

   cadp_aux_file #(
      .N(AUX_N),
      .W(HALF_W)
   ) u_aux_file (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .ptr_i(aux_pointer),
      .wr_en_i(aux_wr),
      .wr_idx_i(sel),
      .wr_data_i(src_word),
      .mod_en_i(ind_valid_i),
      .mod_mode_i(ind_mode_i),
      .pick_idx_i(sel),
      .cur_o(aux_cur),
      .pick_o(aux_pick)
   );

   // Wishbone slave: one wait state, writes land on the acknowledged edge
   assign wb_take = wb_cyc_i && wb_stb_i && !ack_r;
   assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_take;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ctrl_r <= CTRL_RESET;
      end else if (wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
         ctrl_r <= wb_dat_i[CTRL_W-1:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         rdata_r <= '0;
      end else if (wb_take && !wb_we_i) begin
         rdata_r <= '0;
         unique case (wb_adr_i)
            REG_CTRL: rdata_r[CTRL_W-1:0] <= ctrl_r;
            REG_STATUS: begin
               rdata_r[STAT_CARRY_BIT] <= carry_r;
               rdata_r[STAT_OVF_BIT] <= ovf_r;
               rdata_r[STAT_BUSY_BIT] <= busy;
               rdata_r[STAT_PTR_LSB +: PTR_W] <= aux_pointer;
            end
            REG_ACC: rdata_r <= accumulator_reg;
            REG_AUX: rdata_r[HALF_W-1:0] <= aux_cur;
            default: ;
         endcase
      end
   end

   assign wb_dat_o = rdata_r;
   assign wb_ack_o = ack_r;
   assign store_data_o = store_data_r;
   assign store_valid_o = store_valid_r;
   assign data_addr_o = aux_cur;
   assign aux_pointer_o = aux_pointer;
   assign cond_c_o = carry_r;
   assign cond_nc_o = !carry_r;
   assign overflow_o = ovf_r;
   assign acc_o = accumulator_reg;

   a_carry_reset: assert property (
      @(posedge clock_i) disable iff (reset_i) $fell(reset_i) |-> carry_r && cond_c_o)
      else $error("carry not one after reset");
   a_carry_untouched: assert property (
      @(posedge clock_i) disable iff (reset_i)
      exec && (eop inside {load_acc_op, and_op, or_op, xor_op, load_aux_op, store_high_op}) |=> $stable(carry_r))
      else $error("non-arithmetic op changed carry");
   a_carry_input: assert property (
      @(posedge clock_i) disable iff (reset_i)
      exec && eop == add_with_carry_op && !saturation_enable
      |=> accumulator_reg == $past(accumulator_reg) + $past(opnd_ext) + $past(carry_r))
      else $error("add with carry ignored old carry");
   a_high_carry_keep: assert property (
      @(posedge clock_i) disable iff (reset_i)
      exec && ((eop == add_high_op && carry_r) || (eop == sub_high_op && !carry_r)) |=> $stable(carry_r))
      else $error("high-half op disturbed carry");
   a_flag_direct: assert property (
      @(posedge clock_i) disable iff (reset_i)
      exec && eop inside {set_flag_op, clear_flag_op}
      |=> cond_c_o == $past(eop == set_flag_op) && cond_nc_o == !cond_c_o)
      else $error("set or clear flag wrong");
   a_store_high: assert property (
      @(posedge clock_i) disable iff (reset_i)
      exec && eop == store_high_op |=> store_valid_o && store_data_o == $past(store_hi_w)
      && accumulator_reg == $past(accumulator_reg))
      else $error("high store wrong or accumulator changed");
   a_shift_left: assert property (
      @(posedge clock_i) disable iff (reset_i)
      exec && eop == shift_left_one_op |=> accumulator_reg == ($past(accumulator_reg) << 1) && carry_r == $past(acc_msb))
      else $error("left shift wrong");
   a_shift_right: assert property (
      @(posedge clock_i) disable iff (reset_i)
      exec && eop == shift_right_one_op
      |=> acc_msb == ($past(sign_extend_mode) & $past(acc_msb)) && carry_r == $past(acc_lsb))
      else $error("right shift top bit or carry wrong");
   a_rotate_left: assert property (
      @(posedge clock_i) disable iff (reset_i)
      exec && eop == rotate_left_op |=> acc_lsb == $past(carry_r) && carry_r == $past(acc_msb))
      else $error("rotate left wrong");
   a_repeat_length: assert property (
      @(posedge clock_i) disable iff (reset_i)
      op_valid_i && op_ready_o && op_count_i == 8'h02 |=> !op_ready_o [*2] ##1 op_ready_o)
      else $error("repeat length wrong");
   a_saturate_value: assert property (
      @(posedge clock_i) disable iff (reset_i)
      exec && ovf && saturation_enable |=> overflow_o && accumulator_reg == $past(sat_val))
      else $error("saturation value wrong");
   a_index_step: assert property (
      @(posedge clock_i) disable iff (reset_i)
      ind_valid_i && ind_mode_i == ind_inc && !aux_wr && !(exec && eop == load_pointer_op)
      |=> data_addr_o == $past(data_addr_o) + 16'h0001)
      else $error("address step wrong");
endmodule : cadp_datapath
`default_nettype wire

// ==== inc/cadp_pkg.sv ====
// How it works
// - Arithmetic and one-bit shift/rotate ops update carry; accumulator, aux and pointer loads and logic ops leave it.
// - Add-with-carry and subtract-with-borrow use the carry held before the op.
// - High-half add only sets carry on carry; high-half subtract only clears on borrow.
// - Two condition outputs: one true with carry set, one true with carry clear.
// - Carry is written directly by set, clear and status-load operations.
// - Reset forces carry to one.
// - Accumulator is 32 bits; high and low halves are stored separately.
// - High and low stores shift left by zero to seven places without changing the accumulator; the aux store is unshifted.
// - Shifted high store drops top bits and fills from the low half.
// - Shifted low store fills vacated low bits with zeros.
// - One-bit shifts and rotates pass bits through the carry.
// - Sign-extend mode set: right shift is arithmetic, sign bit kept.
// - Sign-extend mode clear: right shift is logical, zero enters the top.
// - Left shift ignores sign-extend mode, zero enters bit 0.
// - Any op repeats under the repeat count, one step per cycle.
// - Eight auxiliary registers selected by a 3-bit pointer.
// - Aux registers and pointer load from memory, accumulator, product or immediate.
// - Indirect access modifies current aux by plus/minus one or by index register.
// - Saturation enabled: overflow sets flag and loads the extreme value.
`default_nettype none
package cadp_pkg;
   localparam int ACC_W = 32;
   localparam int HALF_W = 16;
   localparam int AUX_N = 8;
   localparam int PTR_W = 3;
   localparam int SHIFT_W = 3;
   localparam int RPT_W = 8;
   localparam int ADR_W = 8;
   localparam int WB_W = 32;
   localparam int CTRL_W = 2;
   localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADR_W-1:0] REG_ACC = 8'h08;
   localparam logic [ADR_W-1:0] REG_AUX = 8'h0C;
   localparam int CTRL_SXM_BIT = 0;
   localparam int CTRL_OVM_BIT = 1;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h1;
   localparam int STAT_CARRY_BIT = 0;
   localparam int STAT_OVF_BIT = 1;
   localparam int STAT_BUSY_BIT = 2;
   localparam int STAT_PTR_LSB = 3;
   localparam int LOADST_CARRY_BIT = 0;
   localparam int INDEX_REG = 0;
   localparam logic CARRY_RESET = 1'b1;
   localparam logic [ACC_W-1:0] SAT_POS = 32'h7FFFFFFF;
   localparam logic [ACC_W-1:0] SAT_NEG = 32'h80000000;
   localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;

   typedef enum logic [4:0] {
      nop_op, load_acc_op, add_op, sub_op, add_high_op, sub_high_op,
      add_with_carry_op, sub_with_borrow_op, add_product_op, add_aux_op,
      and_op, or_op, xor_op, set_flag_op, clear_flag_op, load_status_op,
      shift_left_one_op, shift_right_one_op, rotate_left_op, rotate_right_op,
      load_aux_op, load_pointer_op, store_high_op, store_low_op, store_aux_op
   } cadp_op_e;

   typedef enum logic [1:0] {src_operand, src_acc, src_product} cadp_src_e;

   typedef enum logic [2:0] {ind_none, ind_inc, ind_dec, ind_add_index, ind_sub_index} cadp_ind_e;
endpackage : cadp_pkg
`default_nettype wire

// ==== test/cadp_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cadp_bus_model #(
   parameter logic [cadp_pkg::ACC_W-1:0] PRODUCT = 32'h00000055
) (
   input wire logic clock_i,                          // CPU clock
   input wire logic store_valid_i,                    // Store strobe
   input wire logic [cadp_pkg::HALF_W-1:0] store_data_i, // Data bus word
   output logic [cadp_pkg::ACC_W-1:0] product_o,      // Product register
   output logic [cadp_pkg::HALF_W-1:0] mem_o          // Last stored word
);
   import cadp_pkg::*;
   assign product_o = PRODUCT;
   // Data memory keeps only the latest stored word
   always_ff @(posedge clock_i) begin
      if (store_valid_i) begin
         mem_o <= store_data_i;
      end
   end
endmodule : cadp_bus_model
`default_nettype wire

// ==== test/cadp_datapath_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module cadp_datapath_test;
   import cadp_pkg::*;
   logic clk = 0, rst = 1, cyc = 0, stb = 0, wwe = 0, op_valid = 0, ind_valid = 0;
   logic [7:0] adr = 8'h00, op_count = 8'h00;
   logic [3:0] wsel = 4'h0;
   logic [31:0] wdat = 32'h0, q, ex;
   cadp_op_e op_code = nop_op;
   logic [15:0] op_operand = 16'h0000;
   logic [2:0] op_shift = 3'h0, aux_sel = 3'h0;
   cadp_src_e aux_src = src_operand;
   cadp_ind_e ind_mode = ind_none;
   wire logic [31:0] wb_dat_o, product, acc_o;
   wire logic [15:0] store_data_o, data_addr_o, mem;
   wire logic [2:0] aux_pointer_o;
   wire logic wb_ack_o, op_ready_o, store_valid_o, cond_c_o, cond_nc_o, overflow_o;
   int n_mismatch = 0, checks_done = 0, busy_n;
   always #2.5 clk = ~clk;
   cadp_datapath i_cadp_datapath (.clock_i(clk), .reset_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe),
      .wb_adr_i(adr), .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .op_valid_i(op_valid), .op_code_i(op_code), .op_operand_i(op_operand), .op_shift_i(op_shift),
      .op_count_i(op_count), .aux_src_i(aux_src), .aux_sel_i(aux_sel), .product_i(product),
      .ind_valid_i(ind_valid), .ind_mode_i(ind_mode), .op_ready_o(op_ready_o), .store_data_o(store_data_o),
      .store_valid_o(store_valid_o), .data_addr_o(data_addr_o), .aux_pointer_o(aux_pointer_o),
      .cond_c_o(cond_c_o), .cond_nc_o(cond_nc_o), .overflow_o(overflow_o), .acc_o(acc_o));
   cadp_bus_model i_cadp_bus_model (.clock_i(clk), .store_valid_i(store_valid_o), .store_data_i(store_data_o),
      .product_o(product), .mem_o(mem));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic carry(input logic c);
      chk("carry", {31'h0, cond_c_o}, {31'h0, c});
      chk("no carry", {31'h0, cond_nc_o}, {31'h0, ~c});
   endtask : carry
   task automatic op(input cadp_op_e c, input logic [15:0] d, input logic [2:0] sh = 3'h0,
      input logic [7:0] n = 8'h00, input logic [2:0] sel = 3'h0, input cadp_src_e src = src_operand);
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= c;
      op_operand <= d;
      op_shift <= sh;
      op_count <= n;
      aux_sel <= sel;
      aux_src <= src;
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      busy_n = 0;
      while (op_ready_o !== 1'b1) begin
         @(posedge clk);
         #1;
         busy_n++;
      end
   endtask : op
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      wwe <= we;
      adr <= a;
      wsel <= 4'hF;
      wdat <= d;
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic ind(input cadp_ind_e m, input logic [15:0] e);
      @(posedge clk);
      ind_valid <= 1'b1;
      ind_mode <= m;
      @(posedge clk);
      ind_valid <= 1'b0;
      #1 chk("address", {16'h0, data_addr_o}, {16'h0, e});
   endtask : ind
   task automatic t_shift;
      carry(1'b1);
      chk("acc", acc_o, 32'h0);
      op(load_acc_op, 16'h0001);
      op(add_high_op, 16'h8000);
      chk("acc", acc_o, 32'h80000001);
      carry(1'b1);
      op(shift_right_one_op, 16'h0);
      chk("acc", acc_o, 32'hC0000000);
      op(clear_flag_op, 16'h0);
      carry(1'b0);
      op(rotate_left_op, 16'h0);
      chk("acc", acc_o, 32'h80000000);
      carry(1'b1);
      op(rotate_right_op, 16'h0);
      chk("acc", acc_o, 32'hC0000000);
      carry(1'b0);
      wb(1'b1, REG_CTRL, 32'h0);
      op(shift_right_one_op, 16'h0);
      chk("acc", acc_o, 32'h60000000);
      op(shift_left_one_op, 16'h0, 3'h0, 8'h02);
      chk("repeat cycles", busy_n, 2);
      chk("acc", acc_o, 32'h0);
      carry(1'b1);
      $display("shift test done");
   endtask : t_shift
   task automatic t_add;
      op(load_acc_op, 16'h0005);
      carry(1'b1);
      op(add_with_carry_op, 16'h0003);
      chk("acc", acc_o, 32'h9);
      carry(1'b0);
      op(set_flag_op, 16'h0);
      carry(1'b1);
      op(load_status_op, 16'h0000);
      carry(1'b0);
      $display("add test done");
   endtask : t_add
   task automatic t_store;
      op(load_acc_op, 16'h1234);
      op(add_high_op, 16'hABCD);
      carry(1'b0);
      for (int s = 0; s < 8; s++) begin
         ex = 32'hABCD1234 << s;
         op(store_high_op, 16'h0, 3'(s));
         chk("high store", {16'h0, store_data_o}, {16'h0, ex[31:16]});
         op(store_low_op, 16'h0, 3'(s));
         chk("low store", {16'h0, store_data_o}, {16'h0, ex[15:0]});
         chk("acc kept", acc_o, 32'hABCD1234);
      end
      @(posedge clk);
      #1 chk("memory", {16'h0, mem}, {16'h0, ex[15:0]});
      $display("store test done");
   endtask : t_store
   task automatic t_aux;
      for (int i = 0; i < 8; i++) begin
         op(load_aux_op, 16'h0100 + 16'(i), 3'h0, 8'h00, 3'(i));
      end
      op(load_pointer_op, 16'h0003);
      chk("pointer", {29'h0, aux_pointer_o}, 32'h3);
      chk("address", {16'h0, data_addr_o}, 32'h0103);
      ind(ind_add_index, 16'h0203);
      ind(ind_inc, 16'h0204);
      ind(ind_dec, 16'h0203);
      ind(ind_sub_index, 16'h0103);
      op(load_aux_op, 16'h0, 3'h0, 8'h00, 3'h7, src_product);
      op(load_pointer_op, 16'h0007);
      chk("address", {16'h0, data_addr_o}, 32'h0055);
      $display("aux test done");
   endtask : t_aux
   task automatic t_sat;
      wb(1'b1, REG_CTRL, 32'h2);
      op(load_acc_op, 16'h0);
      op(add_high_op, 16'h7FFF);
      op(add_high_op, 16'h7FFF);
      chk("acc", acc_o, SAT_POS);
      chk("overflow", {31'h0, overflow_o}, 32'h1);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("status", {31'h0, q[STAT_OVF_BIT]}, 32'h1);
      wb(1'b1, REG_STATUS, 32'h2);
      @(posedge clk);
      #1 chk("overflow", {31'h0, overflow_o}, 32'h0);
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped", q, 32'h0);
      $display("saturation test done");
   endtask : t_sat
   task automatic t_misc;
      wb(1'b1, REG_CTRL, 32'h1);
      op(load_acc_op, 16'h0010);
      op(sub_op, 16'h0011);
      chk("acc", acc_o, 32'hFFFFFFFF);
      carry(1'b0);
      op(sub_with_borrow_op, 16'h0001);
      chk("acc", acc_o, 32'hFFFFFFFD);
      carry(1'b1);
      op(sub_high_op, 16'h0001);
      op(sub_high_op, 16'hFFFF);
      chk("acc", acc_o, 32'hFFFFFFFD);
      carry(1'b0);
      op(add_high_op, 16'h0002);
      chk("acc", acc_o, 32'h0001FFFD);
      carry(1'b1);
      op(and_op, 16'h00F0);
      op(or_op, 16'h0F0F);
      op(xor_op, 16'h00FF);
      chk("acc", acc_o, 32'h00000F00);
      carry(1'b1);
      op(add_aux_op, 16'h0, 3'h0, 8'h00, 3'h7);
      op(add_product_op, 16'h0);
      op(add_op, 16'hFFFF);
      chk("acc", acc_o, 32'h00000FA9);
      carry(1'b1);
      op(load_aux_op, 16'h0, 3'h0, 8'h00, 3'h6, src_acc);
      op(store_aux_op, 16'h0, 3'h0, 8'h00, 3'h6);
      chk("aux store", {16'h0, store_data_o}, 32'h00000FA9);
      $display("mixed test done");
   endtask : t_misc
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      t_shift();
      t_add();
      t_store();
      t_aux();
      t_sat();
      t_misc();
      results();
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      results();
   end
endmodule : cadp_datapath_test
`default_nettype wire
